// ==== serial_port_zero_defs.vh ====
// constants for serial port zero: register indices, field positions, reset values, timing counts
`ifndef SERIAL_PORT_ZERO_DEFS_VH
`define SERIAL_PORT_ZERO_DEFS_VH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define IDX_SERIAL_CONTROL 10'h098
`define IDX_SERIAL_BUFFER 10'h099
`define IDX_POWER_CONTROL 10'h0A0
`define IDX_BAUD_DIVISOR 10'h0A1
`define IDX_IRQ_STATUS 10'h0A2
`define IDX_IRQ_MASK 10'h0A3

// ****************************************
// serial_control field positions
// ****************************************
`define BIT_MODE0_FE 7
`define BIT_MODE1 6
`define BIT_MPE 5
`define BIT_REN 4
`define BIT_TX_NINTH 3
`define BIT_RX_NINTH 2
`define BIT_TX_DONE 1
`define BIT_RX_DONE 0

// ****************************************
// power_control_reg and interrupt fields
// ****************************************
`define BIT_FE_SELECT 0
`define BIT_MODE2_FAST 1
`define IRQ_RX_DONE 0
`define IRQ_TX_DONE 1
`define IRQ_FRAME_ERR 2

// ****************************************
// reset values
// ****************************************
`define RST_CONTROL 8'h00
`define RST_POWER 2'h0
`define RST_BAUD_DIV 16'h00D9
`define RST_IRQ 3'h0

// ****************************************
// bit times in oscillator periods
// ****************************************
`define M0_SLOW_CYC 16'h000C
`define M0_FAST_CYC 16'h0004
`define M2_SLOW_CYC 16'h0040
`define M2_FAST_CYC 16'h0020
`define MIN_BIT_CYC 16'h0002

`endif

// ==== bit_sync.v ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module bit_sync #(
    parameter W = 1
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // asynchronous input and synchronised output
    input wire [W-1:0] async_i,
    output reg [W-1:0] sync_o
);
    reg [W-1:0] meta;

    // idle serial lines rest high, so reset to ones
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta <= {W{1'b1}};
            sync_o <= {W{1'b1}};
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule // bit_sync

// ==== rate_divider.v ====
// bit-time divider: period counter with mid-point and half-period markers
`timescale 1ns/1ps
module rate_divider (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // control
    input wire restart_i,
    input wire [15:0] period_i,
    // timing marks
    output wire tick_o,
    output wire mid_o,
    output wire high_o
);
    reg [15:0] cnt;
    wire [15:0] half = {1'b0, period_i[15:1]};

    assign tick_o = (cnt == period_i - 16'h0001);
    assign mid_o = (cnt == half - 16'h0001);
    assign high_o = (cnt >= half);

    // restart aligns the bit grid to a frame start edge
    always @(posedge clk_i) begin
        if (rst_i || restart_i) begin
            cnt <= 16'h0000;
        end else if (tick_o) begin
            cnt <= 16'h0000;
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end
endmodule // rate_divider

// ==== serial_port_zero.v ====
// serial port zero: wishbone register file, frame transmitter and receiver
//
// Notes on behaviour
// - two mode bits select shift or async modes
// - bad stop bit sets frame error bit
// - modes 2/3 multiproc: ninth zero, no rx flag
// - mode 1 multiproc: need valid stop bit
// - mode 0: multiproc bit picks /12 or /4
// - reception only while receive enable set
// - modes 2/3 send software ninth bit
// - rx ninth bit holds ninth or stop
// - tx flag: end bit 8 or stop start
// - rx flag: end bit 8 or mid stop
// - buffer reads rx data, writes tx
`timescale 1ns/1ps
`include "serial_port_zero_defs.vh"
module serial_port_zero #(
    parameter [15:0] BAUD_DIV_RESET = `RST_BAUD_DIV
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone classic slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [11:2] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // serial pins: rxd is two-way in mode 0, txd carries shift clock in mode 0
    input wire rxd_i,
    output wire rxd_o,
    output wire rxd_oe_o,
    output wire txd_o,
    // interrupt
    output wire irq_o
);
    // ****************************************
    // registers
    // ****************************************
    reg mode_bit0_or_frame_error;
    reg mode_bit1;
    reg multiproc_enable;
    reg rx_enable;
    reg tx_ninth_bit;
    reg rx_ninth_bit;
    reg tx_done_flag;
    reg rx_done_flag;
    reg frame_error;
    reg frame_error_select;
    reg mode2_fast;
    reg [15:0] baud_div;
    reg [2:0] irq_status;
    reg [2:0] irq_mask;
    reg [7:0] rx_data;

    reg tx_busy;
    reg [10:0] tx_shift;
    reg [3:0] tx_left;
    reg rx_busy;
    reg [3:0] rx_cnt;
    reg [10:0] rx_shift;
    reg rxd_prev;
    reg [15:0] period;
    reg [7:0] ctl_read;
    reg [31:0] next_dat;
    localparam [7:0] CTL_RESET = `RST_CONTROL;

    wire [1:0] mode = {mode_bit0_or_frame_error, mode_bit1};
    wire mode0 = (mode == 2'b00);
    wire mode1 = (mode == 2'b01);
    wire rxd_s;
    wire tx_tick;
    wire tx_high;
    wire rx_tick;
    wire rx_mid;
    wire rx_high;

    // ****************************************
    // bus decode
    // ****************************************
    wire req = cyc_i && stb_i;
    wire wr = req && we_i && ack_o;
    wire wr_ctl = wr && sel_i[0] && (adr_i == `IDX_SERIAL_CONTROL);
    wire wr_buf = wr && sel_i[0] && (adr_i == `IDX_SERIAL_BUFFER);
    wire wr_pwr = wr && sel_i[0] && (adr_i == `IDX_POWER_CONTROL);
    wire wr_baud = wr && (adr_i == `IDX_BAUD_DIVISOR);
    wire wr_ists = wr && sel_i[0] && (adr_i == `IDX_IRQ_STATUS);
    wire wr_imsk = wr && sel_i[0] && (adr_i == `IDX_IRQ_MASK);

    // ****************************************
    // bit-time selection
    // ****************************************
    always @* begin
        case (mode)
            2'b00: period = multiproc_enable ? `M0_FAST_CYC : `M0_SLOW_CYC;
            2'b10: period = mode2_fast ? `M2_FAST_CYC : `M2_SLOW_CYC;
            default: period = (baud_div < `MIN_BIT_CYC) ? `MIN_BIT_CYC : baud_div;
        endcase
    end

    // ****************************************
    // transmitter
    // ****************************************
    wire tx_step = tx_busy && tx_tick;
    // mode 0 ends after the 8th bit; async flags as the stop bit begins
    wire tx_done_set = tx_step && (mode0 ? (tx_left == 4'h1) : (tx_left == 4'h2));

    rate_divider tx_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .restart_i(wr_buf),
        .period_i(period),
        .tick_o(tx_tick),
        .mid_o(),
        .high_o(tx_high)
    );

    // a write while busy restarts the frame rather than queueing it
    always @(posedge clk_i) begin
        if (rst_i) begin
            tx_busy <= 1'b0;
            tx_shift <= 11'h7FF;
            tx_left <= 4'h0;
        end else if (wr_buf) begin
            tx_busy <= 1'b1;
            case (mode)
                2'b00: begin
                    tx_shift <= {3'h7, dat_i[7:0]};
                    tx_left <= 4'h8;
                end
                2'b01: begin
                    tx_shift <= {2'h3, dat_i[7:0], 1'b0};
                    tx_left <= 4'hA;
                end
                default: begin
                    tx_shift <= {1'b1, tx_ninth_bit, dat_i[7:0], 1'b0};
                    tx_left <= 4'hB;
                end
            endcase
        end else if (tx_step) begin
            tx_shift <= {1'b1, tx_shift[10:1]};
            tx_left <= tx_left - 4'h1;
            if (tx_left == 4'h1) begin
                tx_busy <= 1'b0;
            end
        end
    end

    // ****************************************
    // receiver
    // ****************************************
    bit_sync #(
        .W(1)
    ) rxd_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(rxd_i),
        .sync_o(rxd_s)
    );

    always @(posedge clk_i) begin
        if (rst_i) begin
            rxd_prev <= 1'b1;
        end else begin
            rxd_prev <= rxd_s;
        end
    end

    wire rx_fall = rxd_prev && !rxd_s;
    wire rx_start_async = !rx_busy && rx_enable && !mode0 && rx_fall;
    // mode 0 reception is started by the device, only once the last byte was taken
    wire rx_start_sync = !rx_busy && !tx_busy && rx_enable && mode0 && !rx_done_flag;
    wire rx_start = rx_start_async || rx_start_sync;

    rate_divider rx_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .restart_i(rx_start),
        .period_i(period),
        .tick_o(rx_tick),
        .mid_o(rx_mid),
        .high_o(rx_high)
    );

    wire [10:0] rx_next = {rxd_s, rx_shift[10:1]};
    wire rx_last = rx_busy && rx_mid && !mode0 && (rx_cnt == (mode1 ? 4'h9 : 4'hA));
    wire rx_stop = rxd_s;
    wire rx_ninth = rx_next[9];
    wire [7:0] rx_async_data = mode1 ? rx_next[9:2] : rx_next[8:1];
    // sampled mid-stop, so the flag lands halfway through the stop bit
    wire rx_accept = rx_last && (mode1 ? !(multiproc_enable && !rx_stop)
                                       : !(multiproc_enable && !rx_ninth));
    wire rx0_done = rx_busy && mode0 && rx_tick && (rx_cnt == 4'h8);
    wire rx_done_set = rx_accept || rx0_done;
    wire fe_set = rx_last && !rx_stop;

    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_busy <= 1'b0;
            rx_cnt <= 4'h0;
            rx_shift <= 11'h000;
        end else if (rx_start) begin
            rx_busy <= 1'b1;
            rx_cnt <= 4'h0;
        end else if (rx_busy && !rx_enable) begin
            rx_busy <= 1'b0;
        end else if (rx0_done || rx_last) begin
            rx_busy <= 1'b0;
        end else if (rx_busy && rx_mid) begin
            if (!mode0 && rx_cnt == 4'h0 && rxd_s) begin
                // glitch, not a start bit
                rx_busy <= 1'b0;
            end else begin
                rx_shift <= rx_next;
                rx_cnt <= rx_cnt + 4'h1;
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_data <= 8'h00;
        end else if (rx_accept) begin
            rx_data <= rx_async_data;
        end else if (rx0_done) begin
            rx_data <= rx_shift[10:3];
        end
    end

    // ****************************************
    // control and flag registers
    // ****************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            mode_bit0_or_frame_error <= CTL_RESET[`BIT_MODE0_FE];
            mode_bit1 <= CTL_RESET[`BIT_MODE1];
            multiproc_enable <= CTL_RESET[`BIT_MPE];
            rx_enable <= CTL_RESET[`BIT_REN];
            tx_ninth_bit <= CTL_RESET[`BIT_TX_NINTH];
            rx_ninth_bit <= CTL_RESET[`BIT_RX_NINTH];
            tx_done_flag <= CTL_RESET[`BIT_TX_DONE];
            rx_done_flag <= CTL_RESET[`BIT_RX_DONE];
            frame_error <= 1'b0;
            {mode2_fast, frame_error_select} <= `RST_POWER;
            baud_div <= BAUD_DIV_RESET;
            irq_mask <= `RST_IRQ;
            irq_status <= `RST_IRQ;
        end else begin
            if (wr_ctl) begin
                if (!frame_error_select) begin
                    mode_bit0_or_frame_error <= dat_i[`BIT_MODE0_FE];
                end
                mode_bit1 <= dat_i[`BIT_MODE1];
                multiproc_enable <= dat_i[`BIT_MPE];
                rx_enable <= dat_i[`BIT_REN];
                tx_ninth_bit <= dat_i[`BIT_TX_NINTH];
            end
            if (rx_accept) begin
                rx_ninth_bit <= mode1 ? rx_stop : rx_ninth;
            end else if (wr_ctl) begin
                rx_ninth_bit <= dat_i[`BIT_RX_NINTH];
            end
            tx_done_flag <= tx_done_set | (wr_ctl ? dat_i[`BIT_TX_DONE] : tx_done_flag);
            rx_done_flag <= rx_done_set | (wr_ctl ? dat_i[`BIT_RX_DONE] : rx_done_flag);
            frame_error <= fe_set | ((wr_ctl && frame_error_select) ? dat_i[`BIT_MODE0_FE] : frame_error);
            if (wr_pwr) begin
                frame_error_select <= dat_i[`BIT_FE_SELECT];
                mode2_fast <= dat_i[`BIT_MODE2_FAST];
            end
            if (wr_baud && sel_i[0]) begin
                baud_div[7:0] <= dat_i[7:0];
            end
            if (wr_baud && sel_i[1]) begin
                baud_div[15:8] <= dat_i[15:8];
            end
            if (wr_imsk) begin
                irq_mask <= dat_i[2:0];
            end
            // write one to clear; a same-cycle event keeps its bit set
            irq_status <= {fe_set, tx_done_set, rx_done_set} | (irq_status & ~(wr_ists ? dat_i[2:0] : 3'h0));
        end
    end

    // ****************************************
    // bus read and acknowledge
    // ****************************************
    always @* begin
        ctl_read = {frame_error_select ? frame_error : mode_bit0_or_frame_error, mode_bit1, multiproc_enable,
                    rx_enable, tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag};
        case (adr_i)
            `IDX_SERIAL_CONTROL: next_dat = {24'h000000, ctl_read};
            `IDX_SERIAL_BUFFER: next_dat = {24'h000000, rx_data};
            `IDX_POWER_CONTROL: next_dat = {30'h00000000, mode2_fast, frame_error_select};
            `IDX_BAUD_DIVISOR: next_dat = {16'h0000, baud_div};
            `IDX_IRQ_STATUS: next_dat = {29'h00000000, irq_status};
            `IDX_IRQ_MASK: next_dat = {29'h00000000, irq_mask};
            default: next_dat = 32'h00000000;
        endcase
    end

    // one wait state; unmapped addresses answer with zero data
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= req && !ack_o;
            if (req && !ack_o) begin
                dat_o <= next_dat;
            end
        end
    end

    // ****************************************
    // pins and interrupt
    // ****************************************
    // mode 0: data on rxd, shift clock low in first half of each bit on txd
    assign rxd_o = tx_shift[0];
    assign rxd_oe_o = mode0 && tx_busy;
    assign txd_o = mode0 ? (tx_busy ? tx_high : (rx_busy ? rx_high : 1'b1))
                         : (tx_busy ? tx_shift[0] : 1'b1);
    assign irq_o = |(irq_status & irq_mask);

endmodule // serial_port_zero

// ==== serial_port_zero_checker.sv ====
// concurrent checks on the ports of serial port zero
`timescale 1ns/1ps
`include "serial_port_zero_defs.vh"
module serial_port_zero_checker (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // bus side
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [11:2] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    // pins
    input wire rxd_oe_o,
    input wire txd_o,
    input wire irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ****************************************
    // bus handshake
    // ****************************************
    sequence bus_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence one_ack;
        ##1 ack_o ##1 !ack_o;
    endsequence
    sequence buf_write;
        ack_o && we_i && sel_i[0] && adr_i == `IDX_SERIAL_BUFFER;
    endsequence
    ack_timing_a: assert property (bus_req |-> one_ack)
        else $error("ack not one cycle after request");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    read_width_a: assert property (ack_o && !we_i && adr_i != `IDX_BAUD_DIVISOR |-> dat_o[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    dat_hold_a: assert property (!(cyc_i && stb_i) |=> $stable(dat_o))
        else $error("read data moved without request");
    // ****************************************
    // pins and interrupt
    // ****************************************
    reset_idle_a: assert property ($fell(rst_i) |-> txd_o && !rxd_oe_o && !irq_o && !ack_o && dat_o == 32'h0)
        else $error("outputs not idle after reset");
    txd_hold_a: assert property (!$stable(txd_o) |=> $stable(txd_o))
        else $error("txd level shorter than two cycles");
    tx_start_a: assert property (buf_write |=> !txd_o || rxd_oe_o)
        else $error("buffer write did not start a frame");
    irq_clear_a: assert property ($fell(irq_o) |-> $past(ack_o && we_i))
        else $error("interrupt dropped without a write");
    cover property (buf_write);
endmodule // serial_port_zero_checker

bind serial_port_zero serial_port_zero_checker u_serial_port_zero_checker (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
    .rxd_oe_o(rxd_oe_o), .txd_o(txd_o), .irq_o(irq_o));

// ==== serial_far_end.sv ====
// far-side serial device: sends frames on demand and captures frames from the line
`timescale 1ns/1ps
module serial_far_end (
    // clock
    input wire clk_i,
    // frame request, bits lsb first
    input wire send_i,
    input wire [11:0] frame_i,
    input wire [3:0] nbits_i,
    input wire [7:0] period_i,
    // line
    input wire line_i,
    output reg line_o,
    output reg [11:0] got_o
);
    reg [11:0] sh;
    reg [3:0] sn, rn;
    reg [7:0] sc, rc;
    reg rbusy;
    initial begin
        line_o = 1'b1;
        sn = 4'h0;
        rbusy = 1'b0;
        got_o = 12'h000;
    end
    always @(posedge clk_i) begin
        if (send_i) begin
            sh <= frame_i;
            sn <= nbits_i;
            sc <= period_i - 8'h01;
            line_o <= frame_i[0];
        end else if (sn != 4'h0) begin
            if (sc == 8'h00) begin
                sn <= sn - 4'h1;
                sh <= sh >> 1;
                sc <= period_i - 8'h01;
                // line goes back to idle high once the frame is out
                line_o <= (sn == 4'h1) ? 1'b1 : sh[1];
            end else sc <= sc - 8'h01;
        end
        // capture: sample at mid bit after a falling start edge
        if (!rbusy && line_i === 1'b0) begin
            rbusy <= 1'b1;
            rn <= 4'h0;
            rc <= period_i / 8'h02;
        end else if (rbusy) begin
            if (rc == 8'h00) begin
                got_o[rn] <= line_i;
                rn <= rn + 4'h1;
                rc <= period_i - 8'h01;
                if (rn == nbits_i - 4'h1) rbusy <= 1'b0;
            end else rc <= rc - 8'h01;
        end
    end
endmodule // serial_far_end

// ==== serial_port_zero_tb_top.sv ====
// self-checking bench for serial port zero
`timescale 1ns/1ps
`include "serial_port_zero_defs.vh"
module serial_port_zero_tb_top;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, send = 1'b0;
    reg [11:2] adr_i = 10'h000;
    reg [3:0] sel_i = 4'h0, nbits = 4'hA;
    reg [31:0] dat_i = 32'h0, q;
    reg [11:0] frame = 12'hFFF;
    reg [7:0] period = 8'h08;
    wire [31:0] dat_o;
    wire [11:0] got;
    wire ack_o, rxd_o, rxd_oe_o, txd_o, irq_o, line;
    // mode 0 transmit drives the data pin itself; otherwise the far side owns it
    wire rxd_i = rxd_oe_o ? rxd_o : line;
    integer fail_count = 0, tests_run = 0;
    always #20 clk_i = ~clk_i;
    serial_port_zero #(.BAUD_DIV_RESET(16'h0008)) u_serial_port_zero (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .rxd_i(rxd_i), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o), .irq_o(irq_o));
    serial_far_end u_serial_far_end (.clk_i(clk_i), .send_i(send), .frame_i(frame), .nbits_i(nbits),
        .period_i(period), .line_i(txd_o), .line_o(line), .got_o(got));
    // ****************************************
    // shared tasks
    // ****************************************
    task close_out;
        begin
            if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task check(input [31:0] exp, input [31:0] seen, input [8*16:1] what);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("wrong value %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task wb(input w, input [11:2] a, input [31:0] d, output [31:0] r);
        integer n;
        begin
            @(posedge clk_i);
            cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'hF;
            n = 0;
            do begin
                @(posedge clk_i);
                n = n + 1;
            end while (ack_o !== 1'b1 && n < 50);
            if (ack_o !== 1'b1) begin
                fail_count = fail_count + 1;
                close_out;
            end
            r = dat_o;
            cyc_i <= 1'b0; stb_i <= 1'b0;
        end
    endtask
    task send_frame(input [11:0] f, input [3:0] n, input [7:0] p);
        begin
            @(posedge clk_i);
            frame <= f; nbits <= n; period <= p; send <= 1'b1;
            @(posedge clk_i);
            send <= 1'b0;
            repeat (32'd0 + n * p + p) @(posedge clk_i);
        end
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_reset;
        begin
            wb(0, `IDX_SERIAL_CONTROL, 0, q); check(`RST_CONTROL, q, "control reset");
            wb(1, 10'h3FF, 32'hFFFFFFFF, q); wb(0, 10'h3FF, 0, q); check(0, q, "unmapped");
            wb(0, `IDX_BAUD_DIVISOR, 0, q);
            check(32'h0008, q, "baud reset");
            wb(1, `IDX_BAUD_DIVISOR, 32'hFFFF1234, q);
            wb(0, `IDX_BAUD_DIVISOR, 0, q);
            check(32'h1234, q, "baud written");
            wb(1, `IDX_BAUD_DIVISOR, 32'h0008, q);
        end
    endtask
    task t_tx_modes;
        integer m, n;
        reg [7:0] d;
        reg [11:0] exp;
        begin
            for (m = 1; m < 4; m = m + 1) begin
                d = 8'hA5 ^ m[7:0];
                wb(1, `IDX_SERIAL_CONTROL, {m[1:0], 6'h00} | (m == 3 ? 8'h08 : 8'h00), q);
                nbits <= (m == 1) ? 4'hA : 4'hB; period <= (m == 2) ? 8'h40 : 8'h08;
                wb(1, `IDX_SERIAL_BUFFER, d, q);
                n = 0; q = 0;
                while (q[1] !== 1'b1 && n < 400) begin
                    wb(0, `IDX_SERIAL_CONTROL, 0, q);
                    n = n + 1;
                end
                check(1, q[1], "tx flag");
                // a transmitter that never finishes ends the run here
                if (q[1] !== 1'b1) close_out;
                repeat (130) @(posedge clk_i);
                exp = (m == 1) ? {3'b001, d, 1'b0} : {2'b01, m == 3, d, 1'b0};
                check(exp, (m == 1) ? got & 12'h3FF : got, "tx frame");
            end
        end
    endtask
    task t_rx_mode1;
        begin
            wb(1, `IDX_SERIAL_CONTROL, 8'h40, q); send_frame({3'b111, 8'h3C, 1'b0}, 4'hA, 8'h08);
            wb(0, `IDX_SERIAL_CONTROL, 0, q); check(8'h40, q, "ren off");
            wb(1, `IDX_SERIAL_CONTROL, 8'h50, q); send_frame({3'b111, 8'h3C, 1'b0}, 4'hA, 8'h08);
            wb(0, `IDX_SERIAL_CONTROL, 0, q); check(8'h55, q, "rx flag");
            wb(0, `IDX_SERIAL_BUFFER, 0, q); check(8'h3C, q, "rx data");
            wb(1, `IDX_SERIAL_CONTROL, 8'h50, q); wb(0, `IDX_SERIAL_CONTROL, 0, q);
            check(8'h50, q & 32'hFB, "flag clear");
            wb(1, `IDX_SERIAL_BUFFER, 8'h5A, q); wb(0, `IDX_SERIAL_BUFFER, 0, q); check(8'h3C, q, "rx kept");
            repeat (120) @(posedge clk_i);
            wb(1, `IDX_POWER_CONTROL, 1, q); wb(1, `IDX_SERIAL_CONTROL, 8'h70, q);
            send_frame({3'b110, 8'h3C, 1'b0}, 4'hA, 8'h08);
            wb(0, `IDX_SERIAL_CONTROL, 0, q); check(8'h80, q & 32'h81, "bad stop");
            wb(1, `IDX_SERIAL_CONTROL, 8'h70, q); wb(1, `IDX_POWER_CONTROL, 0, q);
        end
    endtask
    task t_rx_ninth_irq;
        begin
            wb(1, `IDX_IRQ_STATUS, 7, q); wb(1, `IDX_IRQ_MASK, 1, q); wb(1, `IDX_SERIAL_CONTROL, 8'hF0, q);
            send_frame({3'b010, 8'h66, 1'b0}, 4'hB, 8'h08);
            wb(0, `IDX_SERIAL_CONTROL, 0, q); check(0, q[0], "ninth zero");
            check(0, irq_o, "irq idle");
            send_frame({3'b011, 8'h99, 1'b0}, 4'hB, 8'h08);
            wb(0, `IDX_SERIAL_CONTROL, 0, q); check(8'hF5, q, "ninth one");
            check(1, irq_o, "irq set");
            wb(0, `IDX_SERIAL_BUFFER, 0, q); check(8'h99, q, "ninth data");
            wb(1, `IDX_IRQ_MASK, 0, q); @(negedge clk_i); check(0, irq_o, "irq masked");
            wb(1, `IDX_IRQ_MASK, 1, q); @(negedge clk_i); check(1, irq_o, "irq unmasked");
            wb(1, `IDX_IRQ_STATUS, 1, q); @(negedge clk_i); check(0, irq_o, "irq cleared");
        end
    endtask
    task t_mode0;
        integer s, k, lo;
        reg was_lo;
        reg [7:0] sh0;
        begin
            for (s = 0; s < 2; s = s + 1) begin
                wb(1, `IDX_SERIAL_CONTROL, s ? 8'h20 : 8'h00, q); wb(1, `IDX_SERIAL_BUFFER, 8'hC3, q);
                lo = 0;
                was_lo = 1'b0;
                sh0 = 8'h00;
                // low half of each shift clock, eight bits per byte
                for (k = 0; k < 200; k = k + 1) begin
                    @(posedge clk_i);
                    // data pin is taken on the rising shift clock, lsb first
                    if (was_lo && txd_o === 1'b1 && rxd_oe_o === 1'b1) sh0 = {rxd_o, sh0[7:1]};
                    was_lo = (txd_o === 1'b0);
                    if (txd_o === 1'b0) lo = lo + 1;
                end
                check(s ? 16 : 48, lo, "shift low");
                check(8'hC3, sh0, "m0 data");
                wb(0, `IDX_SERIAL_CONTROL, 0, q); check(1, q[1], "m0 tx flag");
            end
            // mode 0 receive: the idle far side leaves the data pin high
            wb(1, `IDX_SERIAL_CONTROL, 8'h30, q);
            repeat (60) @(posedge clk_i);
            wb(0, `IDX_SERIAL_CONTROL, 0, q); check(8'h31, q, "m0 rx flag");
            wb(0, `IDX_SERIAL_BUFFER, 0, q); check(8'hFF, q, "m0 rx data");
        end
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset;
        t_tx_modes;
        t_rx_mode1;
        t_rx_ninth_irq;
        t_mode0;
        close_out;
    end
endmodule // serial_port_zero_tb_top
